/* File: inc/i2s_emu_pkg.sv */
// Constants, register map and carrier types of the serial audio master.
// Assumes a single 50 MHz module clock and a 32-bit AXI4-Lite master.
package i2s_emu_pkg;
  localparam int WORD_W = 32;
  localparam int AXI_AW = 6;
  localparam int PIN_W  = 8;
  localparam int STS_W  = 4;
  localparam int unsigned CLK_HZ = 50_000_000;

  localparam logic [AXI_AW-1:0] A_CTRL = 6'h00;
  localparam logic [AXI_AW-1:0] A_CMP  = 6'h04;
  localparam logic [AXI_AW-1:0] A_MDIV = 6'h08;
  localparam logic [AXI_AW-1:0] A_TXP  = 6'h0C;
  localparam logic [AXI_AW-1:0] A_TXS  = 6'h10;
  localparam logic [AXI_AW-1:0] A_RXP  = 6'h14;
  localparam logic [AXI_AW-1:0] A_RXS  = 6'h18;
  localparam logic [AXI_AW-1:0] A_STS  = 6'h1C;
  localparam logic [AXI_AW-1:0] A_MASK = 6'h20;
  localparam logic [AXI_AW-1:0] A_FLAG = 6'h24;

  localparam int S_TXRDY  = 0;
  localparam int S_RXFULL = 1;
  localparam int S_UNDER  = 2;
  localparam int S_OVER   = 3;

  localparam int PIN_MCLK = 2;
  localparam int PIN_TXD  = 3;
  localparam int PIN_BCLK = 4;
  localparam int PIN_WS   = 5;
  localparam int PIN_RXD  = 6;

  localparam logic [7:0] RST_CMP_HI = 8'h3F;
  localparam logic [7:0] RST_CMP_LO = 8'h07;
  localparam logic [7:0] RST_MDIV   = 8'h01;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic rx_en;
    logic mclk_en;
    logic en;
  } ctrl_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } cmp_t;
endpackage

/* File: rtl/i2s_emu_top.sv */
// Serial audio bus master: bit clock, word select, master clock timers
// and transmit and receive shifters behind an AXI4-Lite register slave.
// Assumes one module clock; the receive data pin is asynchronous to it.
`timescale 1ns/1ps
module i2s_emu_top
  import i2s_emu_pkg::*;
(
  input  wire logic              CLOCK_IN,
  input  wire logic              RST_N_IN,
  input  wire logic [AXI_AW-1:0] S_AXI_AWADDR_IN,
  input  wire logic              S_AXI_AWVALID_IN,
  output logic                   S_AXI_AWREADY_OUT,
  input  wire logic [WORD_W-1:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]        S_AXI_WSTRB_IN,
  input  wire logic              S_AXI_WVALID_IN,
  output logic                   S_AXI_WREADY_OUT,
  output logic [1:0]             S_AXI_BRESP_OUT,
  output logic                   S_AXI_BVALID_OUT,
  input  wire logic              S_AXI_BREADY_IN,
  input  wire logic [AXI_AW-1:0] S_AXI_ARADDR_IN,
  input  wire logic              S_AXI_ARVALID_IN,
  output logic                   S_AXI_ARREADY_OUT,
  output logic [WORD_W-1:0]      S_AXI_RDATA_OUT,
  output logic [1:0]             S_AXI_RRESP_OUT,
  output logic                   S_AXI_RVALID_OUT,
  input  wire logic              S_AXI_RREADY_IN,
  input  wire logic [PIN_W-1:0]  PIN_IN,
  output logic [PIN_W-1:0]       PIN_OUT,
  output logic [PIN_W-1:0]       PIN_OE_N_OUT,
  output logic                   IRQ_OUT,
  output logic                   TX_DMA_REQ_OUT,
  output logic                   RX_DMA_REQ_OUT
);
  logic              aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
  logic [AXI_AW-1:0] awaddr_ff, nxt_awaddr;
  logic [WORD_W-1:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [3:0]        wstrb_ff, nxt_wstrb;
  logic              bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0]        bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic              wr_do, rd_do, rx_rd;
  ctrl_t             ctrl_ff, nxt_ctrl;
  cmp_t              cmp_ff, nxt_cmp;
  logic [7:0]        mdiv_ff, nxt_mdiv;
  logic [STS_W-1:0]  sts_ff, nxt_sts, mask_ff, nxt_mask;
  logic [WORD_W-1:0] txbuf_ff, nxt_txbuf, sr_ff, nxt_sr;
  logic [WORD_W-1:0] rxbuf_ff, nxt_rxbuf, rxsr_ff, nxt_rxsr;
  logic              tx_flag_ff, nxt_tx_flag, rx_flag_ff, nxt_rx_flag;
  logic              bct_en_ff, nxt_bct_en, bclk_ff, nxt_bclk;
  logic [7:0]        bct_lo_ff, nxt_bct_lo, bct_hi_ff, nxt_bct_hi;
  logic              fst_en_ff, nxt_fst_en, fs_ff, nxt_fs;
  logic [15:0]       fcnt_ff, nxt_fcnt;
  logic              mct_en_ff, nxt_mct_en, mclk_ff, nxt_mclk;
  logic [7:0]        mcnt_ff, nxt_mcnt;
  logic              din_s1_ff, din_s2_ff;
  logic              start, word_end, rise, fall, load, tx_wr;
  logic [STS_W-1:0]  ev, clr;
  logic [WORD_W-1:0] wv;
  logic [16:0]       prod;

  function automatic logic [WORD_W-1:0] rev(input logic [WORD_W-1:0] d);
    for (int i = 0; i < WORD_W; i++) begin
      rev[i] = d[WORD_W-1-i];
    end
  endfunction

  function automatic logic [WORD_W-1:0] merge(
    input logic [WORD_W-1:0] old,
    input logic [WORD_W-1:0] nw,
    input logic [3:0]        s
  );
    for (int i = 0; i < 4; i++) begin
      merge[8*i+:8] = s[i] ? nw[8*i+:8] : old[8*i+:8];
    end
  endfunction

  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    return a inside {A_CTRL, A_CMP, A_MDIV, A_TXP, A_TXS, A_RXP, A_RXS,
                     A_STS, A_MASK, A_FLAG};
  endfunction

  assign S_AXI_AWREADY_OUT = !aw_got_ff && !bvalid_ff;
  assign S_AXI_WREADY_OUT  = !w_got_ff && !bvalid_ff;
  assign S_AXI_ARREADY_OUT = !rvalid_ff;
  assign S_AXI_BVALID_OUT  = bvalid_ff;
  assign S_AXI_BRESP_OUT   = bresp_ff;
  assign S_AXI_RVALID_OUT  = rvalid_ff;
  assign S_AXI_RDATA_OUT   = rdata_ff;
  assign S_AXI_RRESP_OUT   = rresp_ff;
  assign wr_do = aw_got_ff && w_got_ff && !bvalid_ff;
  assign rd_do = S_AXI_ARVALID_IN && !rvalid_ff;
  assign rx_rd = rd_do && (S_AXI_ARADDR_IN == A_RXP ||
                           S_AXI_ARADDR_IN == A_RXS);

  // Bus handshakes; address and data are captured in either order.
  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w_got  = w_got_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
      nxt_w_got = 1'b1;
      nxt_wdata = S_AXI_WDATA_IN;
      nxt_wstrb = S_AXI_WSTRB_IN;
    end
    if (wr_do) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && S_AXI_BREADY_IN) begin
      nxt_bvalid = 1'b0;
    end
    if (rd_do) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = mapped(S_AXI_ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
      case (S_AXI_ARADDR_IN)
        A_CTRL:  nxt_rdata = WORD_W'(ctrl_ff);
        A_CMP:   nxt_rdata = WORD_W'(cmp_ff);
        A_MDIV:  nxt_rdata = WORD_W'(mdiv_ff);
        A_RXP:   nxt_rdata = rev(rxbuf_ff);
        A_RXS:   nxt_rdata = rxbuf_ff;
        A_STS:   nxt_rdata = WORD_W'(sts_ff);
        A_MASK:  nxt_rdata = WORD_W'(mask_ff);
        A_FLAG:  nxt_rdata = WORD_W'({fst_en_ff, bct_en_ff, rx_flag_ff,
                                      tx_flag_ff});
        default: nxt_rdata = '0;
      endcase
    end else if (rvalid_ff && S_AXI_RREADY_IN) begin
      nxt_rvalid = 1'b0;
    end
  end

  // Timers, shifters and register file, all on the module clock.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_cmp  = cmp_ff;
    nxt_mdiv = mdiv_ff;
    nxt_mask = mask_ff;
    nxt_txbuf = txbuf_ff;
    nxt_sr = sr_ff;
    nxt_rxbuf = rxbuf_ff;
    nxt_rxsr = rxsr_ff;
    nxt_tx_flag = tx_flag_ff;
    nxt_rx_flag = rx_flag_ff;
    nxt_bct_en = bct_en_ff;
    nxt_bclk = bclk_ff;
    nxt_bct_lo = bct_lo_ff;
    nxt_bct_hi = bct_hi_ff;
    nxt_fst_en = fst_en_ff;
    nxt_fs = fs_ff;
    nxt_fcnt = fcnt_ff;
    nxt_mct_en = mct_en_ff;
    nxt_mclk = mclk_ff;
    nxt_mcnt = mcnt_ff;
    tx_wr = 1'b0;
    ev = '0;
    clr = '0;
    wv = '0;
    if (wr_do) begin
      case (awaddr_ff)
        A_CTRL: begin
          wv = merge(WORD_W'(ctrl_ff), wdata_ff, wstrb_ff);
          nxt_ctrl = ctrl_t'(wv[2:0]);
        end
        A_CMP: begin
          wv = merge(WORD_W'(cmp_ff), wdata_ff, wstrb_ff);
          nxt_cmp = cmp_t'(wv[15:0]);
        end
        A_MDIV: begin
          wv = merge(WORD_W'(mdiv_ff), wdata_ff, wstrb_ff);
          nxt_mdiv = wv[7:0];
        end
        A_MASK: begin
          wv = merge(WORD_W'(mask_ff), wdata_ff, wstrb_ff);
          nxt_mask = wv[STS_W-1:0];
        end
        A_TXP: begin
          tx_wr = 1'b1;
          nxt_txbuf = rev(wdata_ff);
        end
        A_TXS: begin
          tx_wr = 1'b1;
          nxt_txbuf = wdata_ff;
        end
        A_STS: clr = wdata_ff[STS_W-1:0] & {STS_W{wstrb_ff[0]}};
        default: ;
      endcase
    end
    start = ctrl_ff.en && !tx_flag_ff && !bct_en_ff;
    word_end = bct_en_ff && bct_lo_ff == 8'h00 && bct_hi_ff == 8'h00;
    rise = bct_en_ff && bct_lo_ff == 8'h00 && !bclk_ff;
    fall = bct_en_ff && bct_lo_ff == 8'h00 && bclk_ff;
    load = start || word_end;
    if (!ctrl_ff.en) begin
      nxt_bct_en = 1'b0;
      nxt_bclk = 1'b1;
    end else if (start) begin
      nxt_bct_en = 1'b1;
      nxt_bclk = 1'b1;
      nxt_bct_lo = cmp_ff.lo;
      nxt_bct_hi = cmp_ff.hi;
    end else if (bct_en_ff) begin
      if (bct_lo_ff == 8'h00) begin
        nxt_bct_lo = cmp_ff.lo;
        nxt_bclk = !bclk_ff;
        nxt_bct_hi = word_end ? cmp_ff.hi : bct_hi_ff - 8'h01;
      end else begin
        nxt_bct_lo = bct_lo_ff - 8'h01;
      end
    end
    if (load) begin
      if (!tx_flag_ff) begin
        nxt_sr = txbuf_ff;
        nxt_tx_flag = 1'b1;
        ev[S_TXRDY] = 1'b1;
      end else begin
        nxt_sr = '0;
        ev[S_UNDER] = 1'b1;
      end
    end else if (rise) begin
      nxt_sr = {sr_ff[WORD_W-2:0], 1'b0};
    end
    if (tx_wr) begin
      nxt_tx_flag = 1'b0;
    end
    if (fall) begin
      nxt_rxsr = {rxsr_ff[WORD_W-2:0], din_s2_ff};
    end
    if (rx_rd) begin
      nxt_rx_flag = 1'b0;
    end
    if (word_end && ctrl_ff.rx_en) begin
      nxt_rxbuf = rxsr_ff;
      nxt_rx_flag = 1'b1;
      ev[S_RXFULL] = 1'b1;
      ev[S_OVER] = rx_flag_ff && !rx_rd;
    end
    prod = (17'(cmp_ff.hi) + 17'h1) * (17'(cmp_ff.lo) + 17'h1);
    if (start) begin
      nxt_fst_en = 1'b1;
      nxt_fs = 1'b1;
      nxt_fcnt = 16'(prod - 17'h1);
    end else if (fst_en_ff) begin
      if (fcnt_ff == 16'h0000) begin
        nxt_fcnt = 16'(prod - 17'h1);
        nxt_fs = !fs_ff;
      end else begin
        nxt_fcnt = fcnt_ff - 16'h0001;
      end
    end
    if (!ctrl_ff.mclk_en) begin
      nxt_mct_en = 1'b0;
      nxt_mclk = 1'b0;
    end else if (!mct_en_ff) begin
      nxt_mct_en = 1'b1;
      nxt_mclk = 1'b1;
      nxt_mcnt = mdiv_ff;
    end else if (mcnt_ff == 8'h00) begin
      nxt_mcnt = mdiv_ff;
      nxt_mclk = !mclk_ff;
    end else begin
      nxt_mcnt = mcnt_ff - 8'h01;
    end
    nxt_sts = (sts_ff & ~clr) | ev;
  end

  always_ff @(posedge CLOCK_IN) begin
    din_s1_ff <= PIN_IN[PIN_RXD];
    din_s2_ff <= din_s1_ff;
    if (!RST_N_IN) begin
      {aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff} <= 4'h0;
      {awaddr_ff, wstrb_ff, bresp_ff, rresp_ff} <= '0;
      {wdata_ff, rdata_ff} <= '0;
      ctrl_ff <= '0;
      cmp_ff <= {RST_CMP_HI, RST_CMP_LO};
      mdiv_ff <= RST_MDIV;
      {sts_ff, mask_ff} <= '0;
      {txbuf_ff, sr_ff, rxbuf_ff, rxsr_ff} <= '0;
      tx_flag_ff <= 1'b1;
      rx_flag_ff <= 1'b0;
      {bct_en_ff, bct_lo_ff, bct_hi_ff} <= '0;
      bclk_ff <= 1'b1;
      {fst_en_ff, fs_ff, fcnt_ff} <= '0;
      {mct_en_ff, mclk_ff, mcnt_ff} <= '0;
    end else begin
      aw_got_ff <= nxt_aw_got;
      awaddr_ff <= nxt_awaddr;
      w_got_ff <= nxt_w_got;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      ctrl_ff <= nxt_ctrl;
      cmp_ff <= nxt_cmp;
      mdiv_ff <= nxt_mdiv;
      sts_ff <= nxt_sts;
      mask_ff <= nxt_mask;
      txbuf_ff <= nxt_txbuf;
      sr_ff <= nxt_sr;
      rxbuf_ff <= nxt_rxbuf;
      rxsr_ff <= nxt_rxsr;
      tx_flag_ff <= nxt_tx_flag;
      rx_flag_ff <= nxt_rx_flag;
      bct_en_ff <= nxt_bct_en;
      bclk_ff <= nxt_bclk;
      bct_lo_ff <= nxt_bct_lo;
      bct_hi_ff <= nxt_bct_hi;
      fst_en_ff <= nxt_fst_en;
      fs_ff <= nxt_fs;
      fcnt_ff <= nxt_fcnt;
      mct_en_ff <= nxt_mct_en;
      mclk_ff <= nxt_mclk;
      mcnt_ff <= nxt_mcnt;
    end
  end

  always_comb begin
    PIN_OUT = '0;
    PIN_OE_N_OUT = '1;
    PIN_OUT[PIN_MCLK] = mclk_ff;
    PIN_OUT[PIN_TXD] = sr_ff[WORD_W-1];
    PIN_OUT[PIN_BCLK] = bclk_ff;
    PIN_OUT[PIN_WS] = !fs_ff;
    PIN_OE_N_OUT[PIN_MCLK] = 1'b0;
    PIN_OE_N_OUT[PIN_TXD] = 1'b0;
    PIN_OE_N_OUT[PIN_BCLK] = 1'b0;
    PIN_OE_N_OUT[PIN_WS] = 1'b0;
  end

  assign IRQ_OUT = |(sts_ff & mask_ff);
  assign TX_DMA_REQ_OUT = tx_flag_ff && ctrl_ff.en;
  assign RX_DMA_REQ_OUT = rx_flag_ff;

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);

  bclk_idle_a: assert property (!bct_en_ff |-> bclk_ff)
    else $error("bit clock not idle high");
  trig_src_a: assert property ($rose(bct_en_ff) |->
    $past(tx_flag_ff) == 1'b0 && bclk_ff)
    else $error("bit clock timer started without a word");
  fs_with_bct_a: assert property (bct_en_ff |-> fst_en_ff)
    else $error("frame sync timer not enabled");
  fs_never_off_a: assert property (fst_en_ff |=> fst_en_ff)
    else $error("frame sync timer disabled");
  ws_per_word_a: assert property (word_end |=> $changed(fs_ff))
    else $error("word select not aligned to word end");
  data_on_rise_a: assert property ($changed(sr_ff[WORD_W-1]) |->
    $rose(bclk_ff) || $rose(bct_en_ff))
    else $error("serial data changed off the rising edge");
  reload_flag_a: assert property (load && !tx_flag_ff && !tx_wr
    |=> tx_flag_ff && sr_ff == $past(txbuf_ff))
    else $error("word load did not refill flag");
  rx_sample_a: assert property ($fell(bclk_ff) |->
    rxsr_ff[0] == $past(din_s2_ff))
    else $error("receive bit not taken on falling edge");
  rx_full_a: assert property (word_end && ctrl_ff.rx_en |=>
    rx_flag_ff && rxbuf_ff == $past(rxsr_ff))
    else $error("received word not stored");
  tx_irq_a: assert property (load && !tx_flag_ff && mask_ff[S_TXRDY]
    |=> IRQ_OUT)
    else $error("transmit ready did not interrupt");
  // The sample right after a rise still shows the rise itself, so the hold
  // is checked from the second sample on; short half periods are exempt.
  half_period_a: assert property (rise && cmp_ff.lo > 8'h01 |=>
    ##1 !$changed(bclk_ff) [*2] or $changed(cmp_ff) or !ctrl_ff.en)
    else $error("bit clock half period too short");

  word_end_c: cover property (word_end ##[1:1000] word_end);
  rx_store_c: cover property (word_end && ctrl_ff.rx_en);
  underrun_c: cover property (ev[S_UNDER] && bct_en_ff);
  irq_c: cover property ($rose(IRQ_OUT));
endmodule

/* File: tb/codec_model.sv */
// Behavioural serial audio codec on the slave side of the link.
// Assumes bit clock and data come straight from the master's pins.
`timescale 1ns/1ps
module codec_model (
  input  wire logic        bclk_in,
  input  wire logic        txd_in,
  input  wire logic [31:0] pat_in,
  output logic             rxd_out,
  output logic [31:0]      word_out,
  output int               count_out
);
  logic [31:0] sh;
  int          falls;

  initial begin
    rxd_out = 1'b0;
    word_out = 32'h0;
    count_out = 0;
    falls = 0;
    sh = 32'h0;
  end

  // Serial data is taken at the falling bit clock edge, MSB first.
  always @(negedge bclk_in) begin
    sh = {sh[30:0], txd_in};
    falls = falls + 1;
    if (falls % 32 == 0) begin
      word_out <= sh;
      count_out <= count_out + 1;
    end
  end

  // Our own data changes just after the rising edge, MSB first.
  always @(posedge bclk_in) begin
    rxd_out <= pat_in[31 - (falls % 32)];
  end
endmodule

/* File: tb/i2s_master_emulation_test.sv */
// Bench for the serial audio master: AXI4-Lite tasks and link checks.
// Assumes the codec model sits on the data and bit clock pins.
`timescale 1ns/1ps
module i2s_master_emulation_test;
  import i2s_emu_pkg::*;
  localparam logic [31:0] WA  = 32'hA5C3_0F96;
  localparam logic [31:0] WB  = 32'h1234_5678;
  localparam logic [31:0] WC  = 32'h0F0F_33CC;
  localparam logic [31:0] PAT = 32'hC0DE_5A17;
  localparam int          HALF = 4;
  localparam int          WORD_CLKS = 64 * HALF;
  logic              clock;
  logic              rst_n;
  logic [AXI_AW-1:0] awaddr;
  logic [AXI_AW-1:0] araddr;
  logic              awvalid;
  logic              wvalid;
  logic              bready;
  logic              arvalid;
  logic              rready;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic              awready;
  logic              wready;
  logic              bvalid;
  logic              arready;
  logic              rvalid;
  logic [1:0]        bresp;
  logic [1:0]        rresp;
  logic [31:0]       rdata;
  logic [7:0]        pout;
  logic [7:0]        poen;
  logic              irq;
  logic              txdma;
  logic              rxdma;
  logic              rxd;
  logic [31:0]       mword;
  int                mcount;
  int                miscompares;
  int                n_tests;
  int                cyc;
  int                bc;
  int                bgap;
  int                wc;
  int                wgap;
  logic              bq;
  logic              wq;
  logic [31:0]       rd;
  logic [1:0]        rs;
  logic              prev;
  int                tg;

  i2s_emu_top i2s_emu_top_inst (
    .CLOCK_IN(clock), .RST_N_IN(rst_n),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready), .PIN_IN({1'b0, rxd, 6'h00}),
    .PIN_OUT(pout), .PIN_OE_N_OUT(poen), .IRQ_OUT(irq),
    .TX_DMA_REQ_OUT(txdma), .RX_DMA_REQ_OUT(rxdma)
  );
  codec_model codec_model_inst (
    .bclk_in(pout[PIN_BCLK]), .txd_in(pout[PIN_TXD]), .pat_in(PAT),
    .rxd_out(rxd), .word_out(mword), .count_out(mcount)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Cycles since the last bit clock and word select change.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    bq <= pout[PIN_BCLK];
    wq <= pout[PIN_WS];
    bc <= (pout[PIN_BCLK] !== bq) ? 1 : bc + 1;
    wc <= (pout[PIN_WS] !== wq) ? 1 : wc + 1;
    if (pout[PIN_BCLK] !== bq) bgap <= bc;
    if (pout[PIN_WS] !== wq) wgap <= wc;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      conclude();
    end
  end

  function automatic logic [31:0] rev32(input logic [31:0] v);
    for (int i = 0; i < 32; i++) rev32[i] = v[31-i];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // Ready rises only after the request is taken, so two calls in a row
    // never assign it twice in one time step.
    bready <= 1'b1;
    do @(posedge clock); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [AXI_AW-1:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clock); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic wait_words(input int n);
    while (mcount < n) @(posedge clock);
  endtask

  task automatic conclude();
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    {miscompares, n_tests, cyc, bc, bgap, wc, wgap, tg} = '0;
    {bq, wq} = 2'b11;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    wstrb <= 4'hF;
    @(posedge clock);
    chk({pout[5:2], poen}, {4'b1100, 8'hC3});
    rdr(A_CMP);
    chk(rd, 32'h0000_3F07);
    rdr(6'h3C);
    chk({rd[29:0], rs}, {30'h0, RESP_SLVERR});
    wr(6'h3C, WA);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    wr(A_CTRL, 32'h2);
    repeat (4) @(posedge clock);
    prev = pout[PIN_MCLK];
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pout[PIN_MCLK] !== prev) tg++;
      prev = pout[PIN_MCLK];
    end
    chk(tg, 10);
    wr(A_CMP, 32'h0000_3F03);
    wr(A_MASK, 32'h3);
    wr(A_TXS, WA);
    wr(A_CTRL, 32'h7);
    rdr(A_FLAG);
    chk(rd, 32'hD);
    chk({31'h0, pout[PIN_WS]}, 32'h0);
    chk({30'h0, irq, txdma}, 32'h3);
    wr(A_STS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(A_TXP, WB);
    chk({31'h0, txdma}, 32'h0);
    wait_words(1);
    chk(mword, WA);
    while (rxdma !== 1'b1) @(posedge clock);
    rdr(A_STS);
    chk(rd, 32'h3);
    rdr(A_RXS);
    chk(rd, PAT);
    chk({31'h0, rxdma}, 32'h0);
    wr(A_STS, 32'h3);
    wr(A_TXS, WC);
    wait_words(2);
    chk(mword, rev32(WB));
    wait_words(3);
    chk(mword, WC);
    chk(bgap, HALF);
    chk(wgap, WORD_CLKS);
    while (rxdma !== 1'b1) @(posedge clock);
    rdr(A_RXP);
    chk(rd, rev32(PAT));
    wait_words(4);
    chk(mword, 32'h0);
    rdr(A_STS);
    chk(rd & 32'h4, 32'h4);
    wr(A_MASK, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wr(A_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(A_CTRL, 32'h6);
    repeat (3) @(posedge clock);
    chk({31'h0, pout[PIN_BCLK]}, 32'h1);
    rdr(A_FLAG);
    chk(rd & 32'hC, 32'h8);
    repeat (300) @(posedge clock);
    chk({31'h0, wc <= WORD_CLKS}, 32'h1);
    conclude();
  end
endmodule
